// [hw/uies_consts.svh]
// register offsets, field positions, reset values and counts for uies
`ifndef UIES_CONSTS_SVH
`define UIES_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define UIES_A_DATA      3'h0
`define UIES_A_MASK      3'h1
`define UIES_A_ISR_FCR   3'h2
`define UIES_A_LCR       3'h3
`define UIES_A_MCR       3'h4
`define UIES_A_LSR       3'h5
`define UIES_A_MSR       3'h6
`define UIES_A_RES1      3'h4
`define UIES_A_RES2      3'h5
`define UIES_A_PAU1      3'h6
`define UIES_A_PAU2      3'h7
`define UIES_A_EFR       3'h2

// ---------------------------------------------------------------
// keys, field positions and reset values
// ---------------------------------------------------------------
`define UIES_LCR_ENH_KEY 8'hbf
`define UIES_LCR_DLAB    7
`define UIES_EFR_ENH     4
`define UIES_RST_BYTE    8'h00

// ---------------------------------------------------------------
// source codes, highest priority first
// ---------------------------------------------------------------
`define UIES_SRC_LSR     6'h06
`define UIES_SRC_TMO     6'h0c
`define UIES_SRC_RXD     6'h04
`define UIES_SRC_TXR     6'h02
`define UIES_SRC_MDM     6'h00
`define UIES_SRC_XOF     6'h10
`define UIES_SRC_FLW     6'h20
`define UIES_SRC_NONE    6'h01

// ---------------------------------------------------------------
// receive trigger levels and timeout figures
// ---------------------------------------------------------------
`define UIES_TRIG_0      5'h01
`define UIES_TRIG_1      5'h04
`define UIES_TRIG_2      5'h08
`define UIES_TRIG_3      5'h0e
`define UIES_TMO_EXTRA   8'h0c
`define UIES_WL_BASE     4'h7

`endif

// [hw/uies_pkg.sv]
// shared types of the uart interrupt enable and status block
package uies_pkg;
  `include "uies_consts.svh"
  typedef logic [7:0] uies_byte_t;
  typedef enum logic [5:0] {
    UIES_LSR  = `UIES_SRC_LSR,
    UIES_TMO  = `UIES_SRC_TMO,
    UIES_RXD  = `UIES_SRC_RXD,
    UIES_TXR  = `UIES_SRC_TXR,
    UIES_MDM  = `UIES_SRC_MDM,
    UIES_XOF  = `UIES_SRC_XOF,
    UIES_FLW  = `UIES_SRC_FLW,
    UIES_NONE = `UIES_SRC_NONE
  } uies_src_t;
endpackage

// [hw/uies_sync.sv]
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module uies_sync #(
  parameter int W = 4
) (
  input  wire logic         i_clk,   // core clock
  input  wire logic         i_rst_n, // async reset, low
  input  wire logic [W-1:0] i_d,     // asynchronous level
  input  wire logic [W-1:0] i_rst_v, // idle level the assertion expects after reset
  output logic      [W-1:0] o_q      // synchronised level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // reset value is a constant: pins idle high
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
    end else begin
      s1_q <= i_d;
      s2_q <= s1_q;
    end
  end

  // a wrong idle level here would fake a modem delta after reset
  sync_idle_a: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) !$past(i_rst_n) |-> o_q == i_rst_v)
    else $error("synchroniser not at idle level after reset");

  assign o_q = s2_q;
endmodule // uies_sync

// [hw/uies_timeout.sv]
// receive timeout timer counted in bit times
`timescale 1ns/10ps
`include "uies_consts.svh"
module uies_timeout (
  input  wire logic       i_clk,       // core clock
  input  wire logic       i_rst_n,     // async reset, low
  input  wire logic       i_restart,   // fifo push or pop
  input  wire logic       i_armed,     // data waiting
  input  wire logic       i_bit_tick,  // one pulse per bit
  input  wire logic [3:0] i_char_bits, // bits per character
  output logic            o_expired    // one-cycle pulse
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       exp_q;
  logic       exp_d;
  logic [7:0] limit;

  // four character times plus twelve bit times
  assign limit = {2'h0, i_char_bits, 2'h0} + `UIES_TMO_EXTRA;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (i_restart || !i_armed) begin
      cnt_d = 8'h00;
    end else if (i_bit_tick && cnt_q != limit) begin
      cnt_d = cnt_q + 8'h01;
      exp_d = (cnt_d == limit);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 8'h00;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign o_expired = exp_q;
endmodule // uies_timeout

// [hw/uies_top.sv]
// interrupt enable, source and status logic of one uart channel
`timescale 1ns/10ps
`include "uies_consts.svh"
module uies_top #(
  parameter int CW = 5
) (
  input  wire logic              I_CORE_CLK,      // core clock
  input  wire logic              I_RESETN,        // async reset, low
  input  wire logic [2:0]        I_ADDR,          // register address
  input  wire logic              I_CS,            // chip select
  input  wire logic              I_RD,            // read strobe
  input  wire logic              I_WR,            // write strobe
  input  wire uies_pkg::uies_byte_t I_WDATA,      // write data
  output uies_pkg::uies_byte_t   O_RDATA,         // read data
  output logic                   O_INT,           // interrupt, high
  input  wire uies_pkg::uies_byte_t I_RX_DATA,    // fifo head char
  input  wire logic [CW-1:0]     I_RX_COUNT,      // rx fifo level
  input  wire logic              I_RX_PUSH,       // char into fifo
  input  wire logic [2:0]        I_RX_TOP_ERR,    // brk,frm,par head
  input  wire logic              I_RX_FIFO_ERR,   // error in fifo
  input  wire logic              I_RX_OVERRUN,    // overrun pulse
  input  wire logic              I_TX_FIFO_EMPTY, // tx fifo empty
  input  wire logic              I_TX_SHIFT_EMPTY,// shifter empty
  input  wire logic              I_BIT_TICK,      // one per bit time
  input  wire logic [3:0]        I_MODEM_N,       // cd,ri,dsr,cts pins
  input  wire logic              I_RTS_N,         // own rts output
  input  wire logic              I_XOFF_MATCH,    // pause char seen
  input  wire logic              I_XON_MATCH,     // resume char seen
  input  wire logic              I_SPEC_MATCH,    // special char seen
  output logic                   O_RX_POP,        // holding read pulse
  output logic                   O_TX_PUSH,       // tx write pulse
  output uies_pkg::uies_byte_t   O_TX_DATA,       // tx write data
  output logic                   O_FIFO_EN,       // fifos enabled
  output logic                   O_SLEEP_EN,      // sleep enabled
  output uies_pkg::uies_byte_t   O_MCR,           // gated modem ctl
  output logic                   O_AUTO_CTS_EN,   // auto cts
  output logic                   O_AUTO_RTS_EN,   // auto rts
  output logic                   O_SPECIAL_SEL,   // special char sel
  output logic [3:0]             O_SWFLOW_MODE,   // sw flow mode
  output uies_pkg::uies_byte_t   O_RESUME1,       // resume char 1
  output uies_pkg::uies_byte_t   O_RESUME2,       // resume char 2
  output uies_pkg::uies_byte_t   O_PAUSE1,        // pause char 1
  output uies_pkg::uies_byte_t   O_PAUSE2         // pause char 2
);
  import uies_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [CW-1:0] trig_level(input logic [1:0] s);
    unique case (s)
      2'h0: trig_level = CW'(`UIES_TRIG_0);
      2'h1: trig_level = CW'(`UIES_TRIG_1);
      2'h2: trig_level = CW'(`UIES_TRIG_2);
      2'h3: trig_level = CW'(`UIES_TRIG_3);
    endcase
  endfunction

  // start + data + parity + stop; 1.5 stop rounds to 2
  // base counts start, five data bits and the first stop bit
  function automatic logic [3:0] char_bits(input uies_byte_t l);
    char_bits = `UIES_WL_BASE + {2'h0, l[1:0]} + {3'h0, l[3]} +
                {3'h0, l[2]};
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  uies_byte_t lcr_q, lcr_d, efr_q, efr_d, ier_q, ier_d;
  uies_byte_t mcr_q, mcr_d, res1_q, res1_d, res2_q, res2_d;
  uies_byte_t pau1_q, pau1_d, pau2_q, pau2_d;
  uies_byte_t rdata_q, rdata_d, txd_q, txd_d, mcro_q, mcro_d;
  logic       fen_q, fen_d;
  logic [1:0] trig_q, trig_d;
  logic       lsri_q, lsri_d, ovr_q, ovr_d, tmo_q, tmo_d;
  logic       tx_q, tx_d, txe_prev_q, txe_prev_d;
  logic [3:0] dmsr_q, dmsr_d, mprev_q, mprev_d;
  logic       xoff_q, xoff_d, spec_q, spec_d;
  logic       rtse_q, rtse_d, ctse_q, ctse_d, rts_prev_q, rts_prev_d;
  logic       int_q, int_d, pop_q, pop_d, push_q, push_d;
  logic       sleep_q, sleep_d;

  logic [3:0] modem_s;
  logic       tmo_fire;
  logic       en, key, dlab, rd, wr, data_rdy, rx_cond;
  logic       rd_rhr, wr_thr, rd_isr, rd_lsr, rd_msr;
  uies_byte_t ie;
  uies_src_t  src;

  uies_sync #(
    .W (4)
  ) u_msync (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RESETN),
    .i_d     (I_MODEM_N),
    .i_rst_v (4'hf),
    .o_q     (modem_s)
  );

  uies_timeout u_tmo (
    .i_clk       (I_CORE_CLK),
    .i_rst_n     (I_RESETN),
    .i_restart   (I_RX_PUSH | rd_rhr),
    .i_armed     (fen_q & data_rdy),
    .i_bit_tick  (I_BIT_TICK),
    .i_char_bits (char_bits(lcr_q)),
    .o_expired   (tmo_fire)
  );

  // ---------------------------------------------------------------
  // decode and priority
  // ---------------------------------------------------------------
  assign en       = efr_q[`UIES_EFR_ENH];
  assign key      = (lcr_q == `UIES_LCR_ENH_KEY);
  assign dlab     = lcr_q[`UIES_LCR_DLAB];
  assign rd       = I_CS & I_RD;
  assign wr       = I_CS & I_WR;
  assign rd_rhr   = rd & !dlab & (I_ADDR == `UIES_A_DATA);
  assign wr_thr   = wr & !dlab & (I_ADDR == `UIES_A_DATA);
  assign rd_isr   = rd & !key & (I_ADDR == `UIES_A_ISR_FCR);
  assign rd_lsr   = rd & !key & (I_ADDR == `UIES_A_LSR);
  assign rd_msr   = rd & !key & (I_ADDR == `UIES_A_MSR);
  assign data_rdy = (I_RX_COUNT != '0);
  assign rx_cond  = fen_q ? (I_RX_COUNT >= trig_level(trig_q))
                          : data_rdy;
  assign ie       = {ier_q[7:4] & {4{en}}, ier_q[3:0]};

  // fixed priority; lower sources wait, nothing is lost
  always_comb begin
    src = UIES_NONE;
    if (ie[2] && lsri_q) begin
      src = UIES_LSR;
    end else if (ie[0] && tmo_q) begin
      src = UIES_TMO;
    end else if (ie[0] && rx_cond) begin
      src = UIES_RXD;
    end else if (ie[1] && tx_q) begin
      src = UIES_TXR;
    end else if (ie[3] && (dmsr_q != 4'h0)) begin
      src = UIES_MDM;
    end else if (ie[5] && (xoff_q || spec_q)) begin
      src = UIES_XOF;
    end else if ((ie[6] && rtse_q) || (ie[7] && ctse_q)) begin
      src = UIES_FLW;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    lcr_d = lcr_q;   efr_d = efr_q;   ier_d = ier_q;   mcr_d = mcr_q;
    res1_d = res1_q; res2_d = res2_q; pau1_d = pau1_q; pau2_d = pau2_q;
    fen_d = fen_q;   trig_d = trig_q; txd_d = txd_q;
    rdata_d = rdata_q;
    pop_d = rd_rhr;
    push_d = wr_thr;
    txe_prev_d = I_TX_FIFO_EMPTY;
    rts_prev_d = I_RTS_N;
    mprev_d = modem_s;

    // register writes
    if (wr) begin
      if (I_ADDR == `UIES_A_LCR) begin
        lcr_d = I_WDATA;
      end else if (key) begin
        unique case (I_ADDR)
          `UIES_A_EFR:  efr_d  = I_WDATA;
          `UIES_A_RES1: res1_d = I_WDATA;
          `UIES_A_RES2: res2_d = I_WDATA;
          `UIES_A_PAU1: pau1_d = I_WDATA;
          `UIES_A_PAU2: pau2_d = I_WDATA;
          default: ;
        endcase
      end else begin
        unique case (I_ADDR)
          `UIES_A_DATA: if (!dlab) begin
            txd_d = I_WDATA;
          end
          `UIES_A_MASK: if (!dlab) begin
            ier_d = {I_WDATA[7:4] & {4{en}}, I_WDATA[3:0]};
          end
          `UIES_A_ISR_FCR: begin
            fen_d = I_WDATA[0];
            // other fields only take with the enable bit set
            if (I_WDATA[0]) begin
              trig_d = I_WDATA[7:6];
            end
          end
          `UIES_A_MCR: mcr_d = {I_WDATA[7:5] & {3{en}}, I_WDATA[4:0]};
          default: ;
        endcase
      end
    end

    // register reads, answered one cycle after the strobe
    if (rd) begin
      rdata_d = 8'h00;
      if (I_ADDR == `UIES_A_LCR) begin
        rdata_d = lcr_q;
      end else if (key) begin
        unique case (I_ADDR)
          `UIES_A_EFR:  rdata_d = efr_q;
          `UIES_A_RES1: rdata_d = res1_q;
          `UIES_A_RES2: rdata_d = res2_q;
          `UIES_A_PAU1: rdata_d = pau1_q;
          `UIES_A_PAU2: rdata_d = pau2_q;
          default: ;
        endcase
      end else begin
        unique case (I_ADDR)
          `UIES_A_DATA:    if (!dlab) begin
            rdata_d = I_RX_DATA;
          end
          `UIES_A_MASK:    if (!dlab) begin
            rdata_d = ier_q;
          end
          `UIES_A_ISR_FCR: rdata_d = {fen_q, fen_q, src};
          `UIES_A_MCR:     rdata_d = mcr_q;
          // polled mode reads these whatever the masks hold
          `UIES_A_LSR:     rdata_d = {I_RX_FIFO_ERR,
                                I_TX_FIFO_EMPTY & I_TX_SHIFT_EMPTY,
                                I_TX_FIFO_EMPTY,
                                I_RX_TOP_ERR,
                                ovr_q, data_rdy};
          `UIES_A_MSR:     rdata_d = {~modem_s, dmsr_q};
          default: ;
        endcase
      end
    end

    // sticky sources; every set wins over its clear
    lsri_d = (lsri_q & !rd_lsr) | I_RX_OVERRUN |
             (rd_rhr & (I_RX_TOP_ERR != 3'h0));
    ovr_d  = (ovr_q & !rd_lsr) | I_RX_OVERRUN;
    tmo_d  = (tmo_q & !rd_rhr) | tmo_fire;
    tx_d   = (tx_q & !wr_thr & !(rd_isr && src == UIES_TXR)) |
             (I_TX_FIFO_EMPTY & !txe_prev_q) |
             (wr & !key & !dlab & (I_ADDR == `UIES_A_MASK) &
              I_WDATA[1] & !ier_q[1] & I_TX_FIFO_EMPTY);
    dmsr_d = (dmsr_q & {4{!rd_msr}}) | (modem_s ^ mprev_q);
    xoff_d = (xoff_q & !I_XON_MATCH & !(rd_isr && src == UIES_XOF)) |
             I_XOFF_MATCH;
    spec_d = (spec_q & !I_RX_PUSH & !(rd_isr && src == UIES_XOF)) |
             I_SPEC_MATCH;
    rtse_d = (rtse_q & !rd_msr) | (I_RTS_N & !rts_prev_q);
    ctse_d = (ctse_q & !rd_msr) | (modem_s[0] & !mprev_q[0]);

    int_d   = (src != UIES_NONE);
    sleep_d = ier_q[4] & en;
    mcro_d  = {mcr_q[7:5] & {3{en}}, mcr_q[4:0]};
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      lcr_q <= `UIES_RST_BYTE;  efr_q <= `UIES_RST_BYTE;
      ier_q <= `UIES_RST_BYTE;
      mcr_q <= `UIES_RST_BYTE;  res1_q <= `UIES_RST_BYTE;
      res2_q <= `UIES_RST_BYTE; pau1_q <= `UIES_RST_BYTE;
      pau2_q <= `UIES_RST_BYTE; rdata_q <= `UIES_RST_BYTE;
      txd_q <= `UIES_RST_BYTE;  mcro_q <= `UIES_RST_BYTE;
      fen_q <= 1'b0;  trig_q <= 2'h0;  lsri_q <= 1'b0; ovr_q <= 1'b0;
      tmo_q <= 1'b0;  tx_q <= 1'b0;    txe_prev_q <= 1'b1;
      dmsr_q <= 4'h0; mprev_q <= 4'hf; xoff_q <= 1'b0; spec_q <= 1'b0;
      rtse_q <= 1'b0; ctse_q <= 1'b0;  rts_prev_q <= 1'b1;
      int_q <= 1'b0;  pop_q <= 1'b0;   push_q <= 1'b0; sleep_q <= 1'b0;
    end else begin
      lcr_q <= lcr_d;   efr_q <= efr_d;   ier_q <= ier_d;
      mcr_q <= mcr_d;   res1_q <= res1_d; res2_q <= res2_d;
      pau1_q <= pau1_d; pau2_q <= pau2_d; rdata_q <= rdata_d;
      txd_q <= txd_d;   mcro_q <= mcro_d;
      fen_q <= fen_d;   trig_q <= trig_d; lsri_q <= lsri_d;
      ovr_q <= ovr_d;   tmo_q <= tmo_d;   tx_q <= tx_d;
      txe_prev_q <= txe_prev_d; dmsr_q <= dmsr_d; mprev_q <= mprev_d;
      xoff_q <= xoff_d; spec_q <= spec_d; rtse_q <= rtse_d;
      ctse_q <= ctse_d; rts_prev_q <= rts_prev_d;
      int_q <= int_d;   pop_q <= pop_d;   push_q <= push_d;
      sleep_q <= sleep_d;
    end
  end

  assign O_RDATA       = rdata_q;
  assign O_INT         = int_q;
  assign O_RX_POP      = pop_q;
  assign O_TX_PUSH     = push_q;
  assign O_TX_DATA     = txd_q;
  assign O_FIFO_EN     = fen_q;
  assign O_SLEEP_EN    = sleep_q;
  assign O_MCR         = mcro_q;
  assign O_AUTO_CTS_EN = efr_q[7];
  assign O_AUTO_RTS_EN = efr_q[6];
  assign O_SPECIAL_SEL = efr_q[5];
  assign O_SWFLOW_MODE = efr_q[3:0];
  assign O_RESUME1     = res1_q;
  assign O_RESUME2     = res2_q;
  assign O_PAUSE1      = pau1_q;
  assign O_PAUSE2      = pau2_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  mask_reset_a: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN) !$past(I_RESETN) |-> ier_q == 8'h00)
    else $error("mask not zero after reset");
  enh_gate_a: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN) !en |=> !O_SLEEP_EN && O_MCR[7:5] == 3'h0)
    else $error("enhanced bit active without enable");
  stat_bit0_a: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN) rd_isr |=> O_RDATA[0] == !O_INT)
    else $error("status bit0 disagrees with interrupt");
  lsr_prio_a: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN) rd_isr && ie[2] && lsri_q
      |=> O_RDATA[5:0] == `UIES_SRC_LSR)
    else $error("line status not reported first");
  rx_trig_a: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN) fen_q && ie[0] &&
      I_RX_COUNT >= trig_level(trig_q) |=> O_INT)
    else $error("trigger reached without interrupt");
  tx_clear_a: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN) wr_thr && !(I_TX_FIFO_EMPTY && !txe_prev_q)
      |=> !tx_q)
    else $error("tx write left transmit ready set");
  tmo_clear_a: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN) rd_rhr && !tmo_fire |=> !tmo_q)
    else $error("holding read left timeout set");
  ovr_show_a: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN) I_RX_OVERRUN ##1 rd_lsr |=> O_RDATA[1])
    else $error("overrun not shown in line status");
  tx_empty_a: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RESETN) rd_lsr |=> !O_RDATA[6] || O_RDATA[5])
    else $error("both-empty without fifo empty");
endmodule // uies_top

// [test/tb_top.sv]
// self-checking bench of the uart interrupt enable and status block
`timescale 1ns/10ps
module tb_top;
  import uies_pkg::*;
  typedef struct {logic [2:0] a; uies_byte_t d; uies_byte_t e;} uies_row_t;
  logic       clk = 1'b0, rst_n = 1'b0, cs, rd, wr, irq, sleep, acts;
  logic       arts, ssel, push = 1'b0, ovr = 1'b0, txe = 1'b0, tse = 1'b0;
  logic       tick = 1'b0, rts_n = 1'b1, xoff = 1'b0, xon = 1'b0;
  logic       spec = 1'b0, ferr = 1'b0;
  logic       pop, txp, fen;
  uies_byte_t txd, modem_control, res1, res2, pau1, pau2;
  logic [2:0] addr, terr = 3'h0;
  logic [3:0] mdm_n = 4'hf, swf;
  logic [4:0] cnt = 5'h00;
  uies_byte_t wdata, rdata, q, rxd = 8'h5a;
  int         fail_count = 0, num_checks = 0;
  uies_row_t  rows [10] = '{'{3'h3, 8'h00, 8'h00}, '{3'h1, 8'hf7, 8'h07},
    '{3'h3, 8'hbf, 8'hbf}, '{3'h2, 8'hd5, 8'hd5}, '{3'h4, 8'h11, 8'h11},
    '{3'h5, 8'h22, 8'h22}, '{3'h6, 8'h33, 8'h33}, '{3'h7, 8'h44, 8'h44},
    '{3'h3, 8'h00, 8'h00}, '{3'h1, 8'hff, 8'hff}};
  always #12.5 clk = ~clk;
  uies_host i_uies_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_cs(cs), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
  uies_top i_uies_top (.I_CORE_CLK(clk), .I_RESETN(rst_n), .I_ADDR(addr),
    .I_CS(cs), .I_RD(rd), .I_WR(wr), .I_WDATA(wdata), .O_RDATA(rdata),
    .O_INT(irq), .I_RX_DATA(rxd), .I_RX_COUNT(cnt), .I_RX_PUSH(push),
    .I_RX_TOP_ERR(terr), .I_RX_FIFO_ERR(ferr), .I_RX_OVERRUN(ovr),
    .I_TX_FIFO_EMPTY(txe), .I_TX_SHIFT_EMPTY(tse), .I_BIT_TICK(tick),
    .I_MODEM_N(mdm_n), .I_RTS_N(rts_n), .I_XOFF_MATCH(xoff),
    .I_XON_MATCH(xon), .I_SPEC_MATCH(spec), .O_RX_POP(pop),
    .O_TX_PUSH(txp), .O_TX_DATA(txd), .O_FIFO_EN(fen),
    .O_SLEEP_EN(sleep), .O_MCR(modem_control), .O_AUTO_CTS_EN(acts),
    .O_AUTO_RTS_EN(arts), .O_SPECIAL_SEL(ssel), .O_SWFLOW_MODE(swf),
    .O_RESUME1(res1), .O_RESUME2(res2), .O_PAUSE1(pau1),
    .O_PAUSE2(pau2));
  task automatic chk(string n, uies_byte_t s, uies_byte_t e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(logic [2:0] a, uies_byte_t d);
    i_uies_host.access(a, 1'b1, d, q);
  endtask
  task automatic rd_chk(string n, logic [2:0] a, uies_byte_t e);
    i_uies_host.access(a, 1'b0, 8'h00, q);
    chk(n, q, e);
  endtask
  task automatic wait_n(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    wait_n(6);
    rst_n = 1'b1;
    rd_chk("mask", 3'h1, 8'h00);
    rd_chk("status", 3'h2, 8'h01);
    $display("reset test done");
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_chk("reg", rows[i].a, rows[i].e);
    end
    chk("resume1", res1, 8'h11);
    chk("resume2", res2, 8'h22);
    chk("pause1", pau1, 8'h33);
    chk("pause2", pau2, 8'h44);
    chk("ctl", {sleep, acts, arts, ssel, swf}, 8'he5);
    $display("register table done");
    wr_reg(3'h2, 8'h41);
    chk("fifo", {7'h00, fen}, 8'h01);
    cnt = 5'h03;
    wait_n(3);
    chk("irq", {7'h00, irq}, 8'h00);
    cnt = 5'h04;
    wait_n(3);
    chk("irq", {7'h00, irq}, 8'h01);
    ovr = 1'b1;
    wait_n(1);
    ovr = 1'b0;
    rd_chk("status", 3'h2, 8'hc6);
    rd_chk("line", 3'h5, 8'h03);
    rd_chk("status", 3'h2, 8'hc4);
    cnt = 5'h03;
    wait_n(3);
    rd_chk("status", 3'h2, 8'hc1);
    $display("trigger test done");
    // seven bit character: 4*7+12 ticks
    tick = 1'b1;
    wait_n(39);
    tick = 1'b0;
    wait_n(3);
    chk("irq", {7'h00, irq}, 8'h00);
    tick = 1'b1;
    wait_n(1);
    tick = 1'b0;
    wait_n(3);
    rd_chk("status", 3'h2, 8'hcc);
    rd_chk("data", 3'h0, 8'h5a);
    chk("pop", {7'h00, pop}, 8'h01);
    rd_chk("status", 3'h2, 8'hc1);
    $display("timeout test done");
    txe = 1'b1;
    wait_n(3);
    rd_chk("status", 3'h2, 8'hc2);
    rd_chk("status", 3'h2, 8'hc1);
    rd_chk("line", 3'h5, 8'h21);
    txe = 1'b0;
    wait_n(2);
    txe = 1'b1;
    wait_n(3);
    wr_reg(3'h0, 8'h3c);
    chk("push", {7'h00, txp}, 8'h01);
    chk("txdata", txd, 8'h3c);
    rd_chk("status", 3'h2, 8'hc1);
    $display("transmit test done");
    mdm_n = 4'he;
    wait_n(5);
    rd_chk("status", 3'h2, 8'hc0);
    rd_chk("modem", 3'h6, 8'h11);
    wr_reg(3'h1, 8'hf7);
    mdm_n = 4'hf;
    wait_n(5);
    rd_chk("status", 3'h2, 8'he0);
    rd_chk("modem", 3'h6, 8'h01);
    rts_n = 1'b0;
    wait_n(2);
    rts_n = 1'b1;
    wait_n(3);
    rd_chk("status", 3'h2, 8'he0);
    rd_chk("modem", 3'h6, 8'h00);
    xoff = 1'b1;
    wait_n(1);
    xoff = 1'b0;
    wait_n(3);
    rd_chk("status", 3'h2, 8'hd0);
    {xoff, spec} = 2'h3;
    wait_n(1);
    {xoff, spec} = 2'h0;
    wait_n(3);
    chk("irq", {7'h00, irq}, 8'h01);
    {xon, push} = 2'h3;
    wait_n(1);
    {xon, push} = 2'h0;
    wait_n(3);
    rd_chk("status", 3'h2, 8'hc1);
    $display("event test done");
    terr = 3'h4;
    ferr = 1'b1;
    tse = 1'b1;
    rd_chk("status", 3'h2, 8'hc1);
    rd_chk("data", 3'h0, 8'h5a);
    rd_chk("status", 3'h2, 8'hc6);
    rd_chk("line", 3'h5, 8'hf1);
    terr = 3'h0;
    ferr = 1'b0;
    rd_chk("status", 3'h2, 8'hc1);
    wr_reg(3'h4, 8'he3);
    rd_chk("mcr", 3'h4, 8'he3);
    chk("omcr", modem_control, 8'he3);
    $display("error test done");
    rst_n = 1'b0;
    wait_n(2);
    rst_n = 1'b1;
    rd_chk("mask", 3'h1, 8'h00);
    chk("ctl", {sleep, acts, arts, ssel, swf}, 8'h00);
    wr_reg(3'h1, 8'h01);
    rd_chk("status", 3'h2, 8'h04);
    wr_reg(3'h4, 8'he3);
    rd_chk("mcr", 3'h4, 8'h03);
    chk("omcr", modem_control, 8'h03);
    $display("second reset done");
    complete_run();
  end
  initial begin
    #200us;
    fail_count++;
    complete_run();
  end
endmodule // tb_top

// [test/uies_host.sv]
// host processor model driving the register bus
`timescale 1ns/10ps
module uies_host (
  input  wire logic       i_clk,   // core clock
  input  wire logic [7:0] i_rdata, // read data
  output logic [2:0]      o_addr,  // address
  output logic            o_cs,    // chip select
  output logic            o_rd,    // read strobe
  output logic            o_wr,    // write strobe
  output logic [7:0]      o_wdata  // write data
);
  initial begin
    {o_addr, o_cs, o_rd, o_wr, o_wdata} = 14'h0000;
  end
  // strobes span exactly one rising edge, so reads pop once
  task automatic access(input logic [2:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge i_clk);
    {o_addr, o_cs, o_rd, o_wr, o_wdata} = {a, 1'b1, ~w, w, d};
    @(negedge i_clk);
    q = i_rdata;
    {o_cs, o_rd, o_wr} = 3'h0;
    // released data must not keep its last value
    o_wdata = ~d;
  endtask
endmodule // uies_host
